// *** ppm_pkg.sv ***
/*
 * Package for the port pin function multiplexer: pin indices, reset values and
 * the supervisor level code that turns pin seven of port six into its input.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ppm_pkg;
    // ==========================================================================
    // Widths and pin indices
    // ==========================================================================
    localparam int          PORT_WIDTH       = 8;
    localparam int          TIMER_PIN_COUNT  = 7;
    localparam int          TIMER_CLK_PIN    = 7;
    localparam int          SERIAL_PIN_COUNT = 4;
    localparam int          SER_CLK_PIN      = 0;
    localparam int          SER_DATA_PIN     = 1;
    localparam int          SER_SCL_PIN      = 2;
    localparam int          MAIN_CLK_PIN     = 4;
    localparam int          SUB_CLK_PIN      = 5;
    localparam int          AUX_CLK_PIN      = 6;
    localparam int          HIZ_SVS_PIN      = 7;
    localparam int          ANALOG_PIN_COUNT = 7;
    localparam int          SVS_IN_PIN       = 7;
    // ==========================================================================
    // Values
    // ==========================================================================
    localparam logic [7:0]  PORT_RESET       = 8'h00;
    localparam logic [2:0]  SYNC_RESET       = 3'h0;
    localparam logic [3:0]  SVS_EXT_LEVEL    = 4'hf;
    localparam logic        GROUND_LEVEL     = 1'b0;
endpackage : ppm_pkg

// *** ppm_port_pin_function_mux.sv ***
/*
 * Pin function multiplexer for ports four, five and six: select, direction and
 * analog-enable bits route each pad to general I/O or a peripheral function.
 * Assumes pads resolve (out, oe) externally, and that peripherals sit on sys_clk.
 */
// Functional notes
// - Select 0: plain I/O, direction bit picks input (0) or output (1).
// - Port four pins 0-6, select 1, dir 0: pin feeds both timer captures.
// - Port four pins 0-6, select 1, dir 1: timer channel output drives pin.
// - Port four pin 7, select 1, dir 0: pin is the timer external clock.
// - Port five pins 0-3, select 1: serial module owns pad direction.
// - Two-wire mode on data/clock pins: pull low only, never drive high.
// - Serial A clock wins shared pin; four-wire serial B forced to three-wire.
// - Port five pins 4-6, select 1, dir 1: main, sub-main, auxiliary clocks out.
// - Port five pin 7, select 1: dir 0 high-z control in, dir 1 supervisor out.
// - Port six pin 7, select 1, dir 1, analog off: pad driven to ground.
// - Port six pin 7 analog: analog input seven; level 15 adds supervisor input.
`timescale 1ns/1ps
module ppm_port_pin_function_mux
    import ppm_pkg::*;
#(
    parameter int W = ppm_pkg::PORT_WIDTH
)(
    input  wire logic         sys_clk,                         // 40 MHz system clock
    input  wire logic         reset,                           // Async reset, active high
    input  wire logic [W-1:0] portFourDirectionBits,           // Port four direction
    input  wire logic [W-1:0] portFourFunctionSelectBits,      // Port four select
    input  wire logic [W-1:0] portFourOut,                     // Port four I/O output data
    input  wire logic [W-1:0] portFourPadIn,                   // Port four pad levels
    input  wire logic [6:0]   secondTimerChannelOutput,        // Timer channel outputs
    input  wire logic [W-1:0] portFiveDirectionBits,           // Port five direction
    input  wire logic [W-1:0] portFiveFunctionSelectBits,      // Port five select
    input  wire logic [W-1:0] portFiveOut,                     // Port five I/O output data
    input  wire logic [W-1:0] portFivePadIn,                   // Port five pad levels
    input  wire logic [3:0]   serialOut,                       // Serial pin output data
    input  wire logic [3:0]   serialOutEnable,                 // Serial pin direction
    input  wire logic         serialTwoWireMode,               // Serial B in two-wire mode
    input  wire logic         serialAClockNeeded,              // Serial A clock uses pin 0
    input  wire logic         serialBFourWireReq,              // Serial B asks four-wire
    input  wire logic         mainClock,                       // Main system clock level
    input  wire logic         subMainClock,                    // Sub-main clock level
    input  wire logic         auxClock,                        // Auxiliary clock level
    input  wire logic         supervisorOutput,                // Supervisor output level
    input  wire logic [W-1:0] portSixDirectionBits,            // Port six direction
    input  wire logic [W-1:0] portSixFunctionSelectBits,       // Port six select
    input  wire logic [W-1:0] portSixOut,                      // Port six I/O output data
    input  wire logic [W-1:0] portSixPadIn,                    // Port six pad levels
    input  wire logic [W-1:0] analogEnableBit,                 // Per-pin analog enable
    input  wire logic [3:0]   supervisorLevelSelect,           // Supervisor level field
    output logic      [W-1:0] portFourPadOut,                  // Port four pad drive
    output logic      [W-1:0] portFourPadOe,                   // Port four output enable
    output logic      [W-1:0] portFourIn,                      // Port four I/O input data
    output logic      [6:0]   timerCaptureA,                   // Timer capture inputs A
    output logic      [6:0]   timerCaptureB,                   // Timer capture inputs B
    output logic              secondTimerExternalClock,        // Timer external clock
    output logic      [W-1:0] portFivePadOut,                  // Port five pad drive
    output logic      [W-1:0] portFivePadOe,                   // Port five output enable
    output logic      [W-1:0] portFiveIn,                      // Port five I/O input data
    output logic      [3:0]   serialIn,                        // Serial pin input data
    output logic              serialBThreeWireForced,          // Serial B held three-wire
    output logic              secondTimerOutputHizControl,     // Timer high-z control
    output logic      [W-1:0] portSixPadOut,                   // Port six pad drive
    output logic      [W-1:0] portSixPadOe,                    // Port six output enable
    output logic      [W-1:0] portSixIn,                       // Port six I/O input data
    output logic      [W-1:0] analogConnect,                   // Pad switched to converter
    output logic              supervisorExternalInput          // Supervisor ext input on
);
    import ppm_pkg::*;

    // ==========================================================================
    // Pad input synchronisers
    // ==========================================================================
    // Three stages per pad; a new level counts once stages two and three agree.
    logic [2:0]   sync4_reg [W];
    logic [2:0]   sync5_reg [W];
    logic [2:0]   sync6_reg [W];
    logic [2:0]   sync4_next [W];
    logic [2:0]   sync5_next [W];
    logic [2:0]   sync6_next [W];
    logic [W-1:0] in4_reg, in5_reg, in6_reg;
    logic [W-1:0] in4_next, in5_next, in6_next;

    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_sync
            always_comb
            begin
                sync4_next[g] = {sync4_reg[g][1:0], portFourPadIn[g]};
                sync5_next[g] = {sync5_reg[g][1:0], portFivePadIn[g]};
                sync6_next[g] = {sync6_reg[g][1:0], portSixPadIn[g]};
                in4_next[g]   = (sync4_reg[g][1] == sync4_reg[g][2]) ? sync4_reg[g][2] : in4_reg[g];
                in5_next[g]   = (sync5_reg[g][1] == sync5_reg[g][2]) ? sync5_reg[g][2] : in5_reg[g];
                in6_next[g]   = (sync6_reg[g][1] == sync6_reg[g][2]) ? sync6_reg[g][2] : in6_reg[g];
            end
            always_ff @(posedge sys_clk or posedge reset)
            begin
                if (reset)
                begin
                    sync4_reg[g] <= SYNC_RESET;
                    sync5_reg[g] <= SYNC_RESET;
                    sync6_reg[g] <= SYNC_RESET;
                end
                else
                begin
                    sync4_reg[g] <= sync4_next[g];
                    sync5_reg[g] <= sync5_next[g];
                    sync6_reg[g] <= sync6_next[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            in4_reg <= PORT_RESET;
            in5_reg <= PORT_RESET;
            in6_reg <= PORT_RESET;
        end
        else
        begin
            in4_reg <= in4_next;
            in5_reg <= in5_next;
            in6_reg <= in6_next;
        end
    end

    // ==========================================================================
    // Routing
    // ==========================================================================
    // Every output is registered, so pad and peripheral views lag one cycle
    // behind the control bits; this keeps outputs glitch free at the cost of
    // latency. Clock outputs therefore show sampled levels, not the raw clocks.
    logic [W-1:0] p4Out_next, p4Oe_next, p4In_next;
    logic [W-1:0] p5Out_next, p5Oe_next, p5In_next;
    logic [W-1:0] p6Out_next, p6Oe_next, p6In_next, ana_next;
    logic [6:0]   capA_next, capB_next;
    logic [3:0]   serIn_next;
    logic         tclk_next, hiz_next, force3_next, supervisor_external_input_next;

    always_comb
    begin
        p4Out_next  = portFourOut;
        p4Oe_next   = portFourDirectionBits;
        p4In_next   = in4_reg;
        capA_next   = '0;
        capB_next   = '0;
        tclk_next   = 1'b0;
        for (int i = 0; i < TIMER_PIN_COUNT; i++)
        begin
            if (portFourFunctionSelectBits[i])
            begin
                if (portFourDirectionBits[i])
                    p4Out_next[i] = secondTimerChannelOutput[i];
                else
                begin
                    capA_next[i] = in4_reg[i];
                    capB_next[i] = in4_reg[i];
                end
            end
        end
        if (portFourFunctionSelectBits[TIMER_CLK_PIN] && !portFourDirectionBits[TIMER_CLK_PIN])
            tclk_next = in4_reg[TIMER_CLK_PIN];

        p5Out_next  = portFiveOut;
        p5Oe_next   = portFiveDirectionBits;
        p5In_next   = in5_reg;
        serIn_next  = '0;
        hiz_next    = 1'b0;
        for (int i = 0; i < SERIAL_PIN_COUNT; i++)
        begin
            if (portFiveFunctionSelectBits[i])
            begin
                p5Oe_next[i]  = serialOutEnable[i];
                p5Out_next[i] = serialOut[i];
                serIn_next[i] = in5_reg[i];
            end
        end
        if (serialTwoWireMode)
        begin
            for (int i = SER_DATA_PIN; i <= SER_SCL_PIN; i++)
            begin
                if (portFiveFunctionSelectBits[i])
                begin
                    p5Out_next[i] = GROUND_LEVEL;
                    p5Oe_next[i]  = serialOutEnable[i] && (serialOut[i] == GROUND_LEVEL);
                end
            end
        end
        force3_next = serialAClockNeeded && serialBFourWireReq;
        if (portFiveFunctionSelectBits[MAIN_CLK_PIN] && portFiveDirectionBits[MAIN_CLK_PIN])
            p5Out_next[MAIN_CLK_PIN] = mainClock;
        if (portFiveFunctionSelectBits[SUB_CLK_PIN] && portFiveDirectionBits[SUB_CLK_PIN])
            p5Out_next[SUB_CLK_PIN] = subMainClock;
        if (portFiveFunctionSelectBits[AUX_CLK_PIN] && portFiveDirectionBits[AUX_CLK_PIN])
            p5Out_next[AUX_CLK_PIN] = auxClock;
        if (portFiveFunctionSelectBits[HIZ_SVS_PIN])
        begin
            if (portFiveDirectionBits[HIZ_SVS_PIN])
                p5Out_next[HIZ_SVS_PIN] = supervisorOutput;
            else
                hiz_next = in5_reg[HIZ_SVS_PIN];
        end

        p6Out_next  = portSixOut;
        p6Oe_next   = portSixDirectionBits;
        p6In_next   = in6_reg;
        ana_next    = analogEnableBit;
        if (portSixFunctionSelectBits[SVS_IN_PIN] && portSixDirectionBits[SVS_IN_PIN])
            p6Out_next[SVS_IN_PIN] = GROUND_LEVEL;
        for (int i = 0; i < W; i++)
        begin
            if (analogEnableBit[i])
            begin
                p6Oe_next[i]  = 1'b0;
                p6Out_next[i] = GROUND_LEVEL;
                p6In_next[i]  = 1'b0;
            end
        end
        supervisor_external_input_next  = analogEnableBit[SVS_IN_PIN] && (supervisorLevelSelect == SVS_EXT_LEVEL);
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            portFourPadOut              <= PORT_RESET;
            portFourPadOe               <= PORT_RESET;
            portFourIn                  <= PORT_RESET;
            timerCaptureA               <= '0;
            timerCaptureB               <= '0;
            secondTimerExternalClock    <= 1'b0;
            portFivePadOut              <= PORT_RESET;
            portFivePadOe               <= PORT_RESET;
            portFiveIn                  <= PORT_RESET;
            serialIn                    <= '0;
            serialBThreeWireForced      <= 1'b0;
            secondTimerOutputHizControl <= 1'b0;
            portSixPadOut               <= PORT_RESET;
            portSixPadOe                <= PORT_RESET;
            portSixIn                   <= PORT_RESET;
            analogConnect               <= PORT_RESET;
            supervisorExternalInput     <= 1'b0;
        end
        else
        begin
            portFourPadOut              <= p4Out_next;
            portFourPadOe               <= p4Oe_next;
            portFourIn                  <= p4In_next;
            timerCaptureA               <= capA_next;
            timerCaptureB               <= capB_next;
            secondTimerExternalClock    <= tclk_next;
            portFivePadOut              <= p5Out_next;
            portFivePadOe               <= p5Oe_next;
            portFiveIn                  <= p5In_next;
            serialIn                    <= serIn_next;
            serialBThreeWireForced      <= force3_next;
            secondTimerOutputHizControl <= hiz_next;
            portSixPadOut               <= p6Out_next;
            portSixPadOe                <= p6Oe_next;
            portSixIn                   <= p6In_next;
            analogConnect               <= ana_next;
            supervisorExternalInput     <= supervisor_external_input_next;
        end
    end
endmodule : ppm_port_pin_function_mux

// *** ppm_sva.sv ***
/* Checker for the pin function mux: output routing against control inputs.
   Assumes it is bound into the mux and sees its ports by name. */
`timescale 1ns/1ps
module ppm_sva
    import ppm_pkg::*;
(
    input wire logic       sys_clk, reset, serialTwoWireMode, serialAClockNeeded, // Clock, reset, serial modes
    input wire logic       serialBFourWireReq, mainClock, subMainClock, auxClock, // Serial request, clocks
    input wire logic       supervisorOutput, serialBThreeWireForced, supervisorExternalInput, // Supervisor
    input wire logic [7:0] portFourDirectionBits, portFourFunctionSelectBits, portFourPadIn, // Port four
    input wire logic [7:0] portFourPadOut, portFourPadOe, portFiveDirectionBits, // Port four, five
    input wire logic [7:0] portFiveFunctionSelectBits, portFivePadOut, portFivePadOe, // Port five
    input wire logic [7:0] portSixDirectionBits, portSixFunctionSelectBits, portSixPadOut, // Port six
    input wire logic [7:0] portSixPadOe, analogEnableBit, analogConnect, // Port six analog
    input wire logic [6:0] secondTimerChannelOutput, timerCaptureA, timerCaptureB, // Timer
    input wire logic [3:0] serialOut, serialOutEnable, supervisorLevelSelect // Serial, level
);
    // ==========================================================================
    // Helper and assertions
    // ==========================================================================
    // Outputs register one cycle late, so the edge right after reset is skipped.
    logic liveReg;
    always_ff @(posedge sys_clk or posedge reset)
        if (reset) liveReg <= 1'b0;
        else liveReg <= 1'b1;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence padHeldHigh;
        (liveReg && portFourFunctionSelectBits[4] && !portFourDirectionBits[4] && portFourPadIn[4]) [*7];
    endsequence
    a_io_direction: assert property (liveReg |-> ($past(~portFourFunctionSelectBits)
        & (portFourPadOe ^ $past(portFourDirectionBits))) == 8'h00) else $error("io direction wrong");
    a_capture_follow: assert property (padHeldHigh |-> timerCaptureA[4] && timerCaptureB[4])
        else $error("capture does not follow pad");
    a_timer_out_drive: assert property (liveReg |-> ($past(portFourFunctionSelectBits[6:0]
        & portFourDirectionBits[6:0]) & ((portFourPadOut[6:0] ^ $past(secondTimerChannelOutput))
        | ~portFourPadOe[6:0])) == 7'h00) else $error("timer output not on pad");
    a_serial_dir_own: assert property (liveReg && !$past(serialTwoWireMode) |->
        ($past(portFiveFunctionSelectBits[3:0]) & (portFivePadOe[3:0] ^ $past(serialOutEnable))) == 4'h0)
        else $error("serial direction not followed");
    a_two_wire_low: assert property (liveReg && $past(serialTwoWireMode && portFiveFunctionSelectBits[2])
        |-> !portFivePadOut[2] && portFivePadOe[2] == $past(serialOutEnable[2] & !serialOut[2]))
        else $error("two-wire pad driven high");
    a_three_wire_force: assert property (liveReg |->
        serialBThreeWireForced == $past(serialAClockNeeded && serialBFourWireReq)) else $error("force wrong");
    a_clock_out: assert property (liveReg |-> ($past(portFiveFunctionSelectBits[6:4]
        & portFiveDirectionBits[6:4]) & (portFivePadOut[6:4] ^ $past({auxClock, subMainClock, mainClock})))
        == 3'h0) else $error("clock not on pad");
    a_supervisor_out: assert property (liveReg && $past(portFiveFunctionSelectBits[7]
        && portFiveDirectionBits[7]) |-> portFivePadOe[7] && portFivePadOut[7] == $past(supervisorOutput))
        else $error("supervisor not on pad");
    a_analog_release: assert property (liveReg |-> analogConnect == $past(analogEnableBit)
        && (portSixPadOe & analogConnect) == 8'h00) else $error("analog pin still driven");
    a_ground_drive: assert property (liveReg && $past(portSixFunctionSelectBits[7]
        && portSixDirectionBits[7] && !analogEnableBit[7]) |-> portSixPadOe[7]
        && portSixPadOut[7] == GROUND_LEVEL) else $error("pin not grounded");
    a_svs_input: assert property (liveReg |-> supervisorExternalInput ==
        $past(analogEnableBit[7] && supervisorLevelSelect == SVS_EXT_LEVEL)) else $error("supervisor input");
endmodule : ppm_sva

// *** ppm_periph_model.sv ***
/* Peripheral model: timer, clock, supervisor and serial output levels.
   Assumes the bench freezes it whenever exact levels are compared. */
`timescale 1ns/1ps
module ppm_periph_model (
    input  wire logic       sys_clk,                  // System clock
    input  wire logic       reset,                    // Async reset, active high
    input  wire logic       freeze,                   // Hold all levels
    output logic      [6:0] secondTimerChannelOutput, // Timer channel levels
    output logic            mainClock,                // Main clock level
    output logic            subMainClock,             // Sub-main clock level
    output logic            auxClock,                 // Auxiliary clock level
    output logic            supervisorOutput,         // Supervisor level
    output logic      [3:0] serialOut                 // Serial output data
);
    // A counter gives each clock and supervisor output a distinct rate, so swapped routes show up.
    logic [7:0] countReg;
    logic [7:0] countNext;
    always_comb
    begin
        countNext = freeze ? countReg : countReg + 8'h01;
    end
    always_ff @(posedge sys_clk or posedge reset)
        if (reset) countReg <= 8'h35;
        else countReg <= countNext;
    assign secondTimerChannelOutput = countReg[6:0];
    assign {supervisorOutput, auxClock, subMainClock, mainClock} = countReg[3:0];
    assign serialOut = countReg[7:4];
endmodule : ppm_periph_model

// *** port_pin_function_mux_test.sv ***
/* Self-checking bench for the pin function mux with a peripheral model.
   Assumes a 40 MHz clock and the registered latencies of the mux. */
`timescale 1ns/1ps
module port_pin_function_mux_test;
    logic sys_clk, reset, freeze, serialTwoWireMode, serialAClockNeeded, serialBFourWireReq, mainClock;
    logic subMainClock, auxClock, supervisorOutput, secondTimerExternalClock, serialBThreeWireForced;
    logic secondTimerOutputHizControl, supervisorExternalInput;
    logic [7:0] portFourDirectionBits, portFourFunctionSelectBits, portFourOut, portFourPadIn, portFourPadOut;
    logic [7:0] portFourPadOe, portFourIn, portFiveDirectionBits, portFiveFunctionSelectBits, portFiveOut;
    logic [7:0] portFivePadIn, portFivePadOut, portFivePadOe, portFiveIn, portSixDirectionBits, portSixOut;
    logic [7:0] portSixFunctionSelectBits, portSixPadIn, portSixPadOut, portSixPadOe, portSixIn;
    logic [7:0] analogEnableBit, analogConnect;
    logic [6:0] secondTimerChannelOutput, timerCaptureA, timerCaptureB;
    logic [3:0] serialOut, serialOutEnable, serialIn, supervisorLevelSelect;
    int err_count = 0;
    int samples_checked = 0;
    ppm_port_pin_function_mux ppm_port_pin_function_mux_i (.*);
    ppm_periph_model ppm_periph_model_i (.sys_clk(sys_clk), .reset(reset), .freeze(freeze),
        .secondTimerChannelOutput(secondTimerChannelOutput), .mainClock(mainClock), .subMainClock(subMainClock),
        .auxClock(auxClock), .supervisorOutput(supervisorOutput), .serialOut(serialOut));
    always #12.5 sys_clk = ~sys_clk;
    // ==========================================================================
    // Tasks
    // ==========================================================================
    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask : chk
    task wait_edges(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wait_edges
    task wrap_up;
        if (err_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    // ==========================================================================
    // Sequence
    // ==========================================================================
    initial
    begin
        {sys_clk, serialTwoWireMode, serialAClockNeeded, serialBFourWireReq, serialOutEnable} = '0;
        {portFourDirectionBits, portFourFunctionSelectBits, portFourOut, portFourPadIn} = '0;
        {portFiveDirectionBits, portFiveFunctionSelectBits, portFiveOut, portFivePadIn} = '0;
        {portSixDirectionBits, portSixFunctionSelectBits, portSixOut, portSixPadIn} = '0;
        {analogEnableBit, supervisorLevelSelect} = '0;
        reset = 1'b1;
        freeze = 1'b1;
        wait_edges(16);
        chk("reset oe", 8'h00, portFourPadOe);
        reset <= 1'b0;
        @(posedge sys_clk);
        portFourDirectionBits <= 8'h0f;
        portFourOut <= 8'ha5;
        portFourPadIn <= 8'h3c;
        portSixPadIn <= 8'h5a;
        wait_edges(6);
        chk("io oe", 8'h0f, portFourPadOe);
        chk("io out", 8'h05, portFourPadOut & portFourPadOe);
        chk("io in", 8'h3c, portFourIn);
        chk("io in six", 8'h5a, portSixIn);
        portFourFunctionSelectBits <= 8'hff;
        portFourOut <= 8'h0a;
        portFourPadIn <= 8'hd0;
        wait_edges(8);
        chk("timer out", {4'h0, secondTimerChannelOutput[3:0]}, portFourPadOut & portFourPadOe);
        chk("timer oe", 8'h0f, portFourPadOe);
        chk("capture a", 8'h50, {1'b0, timerCaptureA});
        chk("capture b", 8'h50, {1'b0, timerCaptureB});
        chk("timer clock", 8'h01, {7'h0, secondTimerExternalClock});
        portFourPadIn <= 8'h00;
        wait_edges(6);
        portFourPadIn <= 8'h10;
        @(posedge sys_clk);
        portFourPadIn <= 8'h00;
        repeat (7)
        begin
            @(posedge sys_clk);
            chk("glitch", 8'h00, {1'b0, timerCaptureA});
        end
        portFiveFunctionSelectBits <= 8'h0f;
        serialOutEnable <= 4'hb;
        portFivePadIn <= 8'h05;
        wait_edges(6);
        chk("serial oe", 8'h0b, portFivePadOe & 8'h0f);
        chk("serial out", {4'h0, serialOut} & 8'h0b, portFivePadOut & 8'h0b);
        chk("serial in", 8'h05, {4'h0, serialIn});
        serialTwoWireMode <= 1'b1;
        serialOutEnable <= 4'hf;
        wait_edges(2);
        chk("two wire out", 8'h00, portFivePadOut & 8'h06);
        chk("two wire oe", {5'h0, ~serialOut[2:1], 1'b0}, portFivePadOe & 8'h06);
        for (int i = 0; i < 4; i++)
        begin
            {serialAClockNeeded, serialBFourWireReq} <= 2'(i);
            wait_edges(2);
            chk("three wire", {7'h0, i == 3}, {7'h0, serialBThreeWireForced});
        end
        portFiveFunctionSelectBits <= 8'hf0;
        portFiveDirectionBits <= 8'h70;
        portFivePadIn <= 8'h80;
        wait_edges(6);
        chk("clock out", {1'b0, auxClock, subMainClock, mainClock, 4'h0}, portFivePadOut & 8'h70);
        chk("hiz in", 8'h01, {7'h0, secondTimerOutputHizControl});
        chk("io in five", 8'h80, portFiveIn);
        portFiveDirectionBits <= 8'hf0;
        portFiveOut <= 8'h80;
        wait_edges(2);
        chk("svs out", {supervisorOutput, 7'h0}, portFivePadOut & portFivePadOe & 8'h80);
        {portSixFunctionSelectBits, portSixDirectionBits, analogEnableBit} <= {8'hff, 8'hff, 8'h7f};
        supervisorLevelSelect <= 4'hf;
        portSixOut <= 8'hff;
        wait_edges(2);
        chk("analog oe", 8'h80, portSixPadOe);
        chk("analog in", 8'h00, portSixIn);
        chk("ground", 8'h00, portSixPadOut & 8'h80);
        chk("analog conn", 8'h7f, analogConnect);
        chk("svs off", 8'h00, {7'h0, supervisorExternalInput});
        analogEnableBit <= 8'hff;
        wait_edges(2);
        chk("svs on", 8'h01, {7'h0, supervisorExternalInput});
        supervisorLevelSelect <= 4'he;
        wait_edges(2);
        chk("svs level", 8'h00, {7'h0, supervisorExternalInput});
        // Free running traffic exercises the checker on moving levels, then a reset in mid-run.
        {freeze, portFourDirectionBits, portFiveDirectionBits, analogEnableBit} <= {1'b0, 8'h7f, 8'hf0, 8'h0f};
        wait_edges(40);
        reset <= 1'b1;
        wait_edges(2);
        chk("reset mid", 8'h00, portFivePadOe);
        reset <= 1'b0;
        wait_edges(20);
        chk("after reset", 8'hf0, portFivePadOe);
        wrap_up;
    end
    initial
    begin
        wait_edges(3000);
        err_count++;
        wrap_up;
    end
endmodule : port_pin_function_mux_test
bind ppm_port_pin_function_mux ppm_sva ppm_sva_i (.*);
